// file: ppp_pkg.sv
/*
 * ppp_pkg: constants and carrier types for the parallel programming port.
 * Assumes a single 200 MHz clock; all pin inputs are synchronous to it.
 */
package ppp_pkg;
    // action selector codes
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    // command codes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    // reset values of nonvolatile bytes (all unprogrammed)
    localparam logic [7:0] FUSE_LO_RST = 8'hFF;
    localparam logic [7:0] FUSE_HI_RST = 8'hFF;
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    // lock byte fields
    localparam int LOCK_BIT_ONE_POS = 0;
    localparam int LOCK_BIT_TWO_POS = 1;
    localparam logic [7:0] LOCK_BOOT_MASK = 8'h3C;
    // programming times
    localparam int CLK_MHZ = 200;
    localparam int T_PROG_US = 5;
    localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
    localparam int SIG_LAST = 2;

    typedef struct packed {
        logic load;
        logic latch;
        logic write_n;
        logic out_en_n;
        logic [1:0] action;
        logic byte_sel_first;
        logic byte_sel_second;
        logic [7:0] data;
    } ppp_pins_t;

    typedef enum logic [1:0] {
        PPP_IDLE = 2'b01,
        PPP_BUSY = 2'b10
    } ppp_state_t;
endpackage

// file: ppp_port.sv
/*
 * ppp_port: device side of the high-voltage parallel programming port with
 * flash and eeprom arrays, page buffer, fuses, lock bits and identity bytes.
 * Assumes the programmer pins are synchronous to sys_clk_i and that the
 * programmer waits for ready_busy high before the next write strobe.
 */
// Overview of operation
// - action 10, low byte select 0, load pulse loads command; 0x10 writes flash
// - action 00, low select 0: load pulse stores low address byte
// - action 01, low select 0: load pulse stores low data byte
// - action 01, low select 1: load pulse stores high data byte
// - low select 1 with page latch pulse copies data word into page buffer
// - low address bits pick word, upper bits pick page during write
// - action 00, low select 1: load pulse stores high address byte
// - low write pulse programs flash page; ready_busy low until done
// - command 0x00 is no operation and clears write controls
// - command 0x11 buffers eeprom bytes; write pulse with select 0 programs
// - command 0x02 reads flash low or high byte by low byte select
// - command 0x03 reads addressed eeprom byte with select 0
// - command 0x40 writes fuse low, high or extended by byte selects
// - command 0x20 writes lock bits from low data byte, 0 programs
// - lock mode 3 blocks programming of boot lock bits
// - lock bits are never cleared by these commands
// - command 0x04 reads fuse low, high, extended or lock by selects
// - command 0x08 reads identity byte at low address 0 to 2
// - command 0x08, address 0, low select 1 reads calibration byte
// - data bus driven from one edge after output enable falls to one edge after it rises
// - action 11 ignores load; ready_busy 0 busy, 1 ready
// - command and address registers persist across operations
`timescale 1ns/1ps
module ppp_port #(
    parameter int FLASH_WORDS = 8192,
    parameter int FLASH_PAGE = 64,
    parameter int EE_BYTES = 512,
    parameter int EE_PAGE = 4,
    parameter int PROG_CYCLES = ppp_pkg::PROG_CYC,
    parameter logic [7:0] SIG0 = 8'h11,  // arbitrary identity value
    parameter logic [7:0] SIG1 = 8'h22,  // arbitrary identity value
    parameter logic [7:0] SIG2 = 8'h33,  // arbitrary identity value
    parameter logic [7:0] CALIB = 8'h80
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic load_strobe_i,
    input wire logic page_latch_i,
    input wire logic write_n_i,
    input wire logic out_en_n_i,
    input wire logic action_sel_hi_i,
    input wire logic action_sel_lo_i,
    input wire logic byte_sel_first_i,
    input wire logic byte_sel_second_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic ready_busy_o
);
    // word index width within a page, then address widths of both arrays
    localparam int FW = $clog2(FLASH_PAGE);
    localparam int EW = $clog2(EE_PAGE);
    localparam int FA = $clog2(FLASH_WORDS);
    localparam int EA = $clog2(EE_BYTES);

    // refuse geometries that the address slicing below cannot serve
    if (FLASH_PAGE < 2 || EE_PAGE < 2 || FLASH_PAGE > 256 || EE_PAGE > 256
        || FLASH_PAGE > FLASH_WORDS || EE_PAGE > EE_BYTES || FA > 16 || EA > 16
        || PROG_CYCLES < 1 || (1 << FW) != FLASH_PAGE || (1 << EW) != EE_PAGE
        || (1 << FA) != FLASH_WORDS || (1 << EA) != EE_BYTES) begin : g_bad_geometry
        $error("ppp_port: unsupported geometry");
    end

    typedef struct packed {
        ppp_pkg::ppp_pins_t pins;
        ppp_pkg::ppp_state_t state;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [15:0] dword;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
        logic [7:0] fuse_ext;
        logic [7:0] lock;
        logic [31:0] cnt;
        logic [7:0] dout;
        logic oe;
        logic rdy;
    } ppp_regs_t;

    ppp_regs_t s_r;
    ppp_regs_t s_nxt;

    // arrays live outside the struct so they can map onto memories
    logic [15:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [15:0] fbuf [FLASH_PAGE];
    logic [7:0] ebuf [EE_PAGE];
    logic [FLASH_PAGE-1:0] fbuf_vld_r;
    logic [EE_PAGE-1:0] ebuf_vld_r;

    ppp_pkg::ppp_pins_t pin_now;
    logic load_rise;
    logic latch_rise;
    logic wr_fall;
    logic [FA-1:0] faddr;
    logic [EA-1:0] eaddr;
    logic [FA-1:0] fpage_base;
    logic [EA-1:0] epage_base;
    logic start_flash;
    logic start_ee;
    logic done;

    assign pin_now = '{load: load_strobe_i, latch: page_latch_i, write_n: write_n_i,
                       out_en_n: out_en_n_i, action: {action_sel_hi_i, action_sel_lo_i},
                       byte_sel_first: byte_sel_first_i,
                       byte_sel_second: byte_sel_second_i, data: data_i};
    assign load_rise = pin_now.load & ~s_r.pins.load;
    assign latch_rise = pin_now.latch & ~s_r.pins.latch;
    // write_n acts on its falling edge; a strobe seen while busy is ignored
    assign wr_fall = ~pin_now.write_n & s_r.pins.write_n;
    assign faddr = s_r.addr[FA-1:0];
    assign eaddr = s_r.addr[EA-1:0];
    // word bits pick the slot, the bits above them up to the array width pick the page
    assign fpage_base = {faddr[FA-1:FW], {FW{1'b0}}};
    assign epage_base = {eaddr[EA-1:EW], {EW{1'b0}}};
    assign done = (s_r.state == ppp_pkg::PPP_BUSY) && (s_r.cnt == 32'h0000_0001);
    assign start_flash = wr_fall && s_r.rdy && s_r.cmd == ppp_pkg::CMD_WR_FLASH;
    // eeprom page programming wants low byte select at 0 on the write pulse
    assign start_ee = wr_fall && s_r.rdy && s_r.cmd == ppp_pkg::CMD_WR_EE
        && !pin_now.byte_sel_first;

    always_comb begin
        s_nxt = s_r;
        // last sample of every pin, kept for edge detection
        s_nxt.pins = pin_now;
        if (load_rise) begin
            if (pin_now.action == ppp_pkg::ACT_CMD && !pin_now.byte_sel_first) begin
                // command and address survive every operation, so reads need no reload
                s_nxt.cmd = pin_now.data;
            end else if (pin_now.action == ppp_pkg::ACT_ADDR) begin
                if (pin_now.byte_sel_first) begin
                    s_nxt.addr[15:8] = pin_now.data;
                end else begin
                    s_nxt.addr[7:0] = pin_now.data;
                end
            end else if (pin_now.action == ppp_pkg::ACT_DATA) begin
                if (pin_now.byte_sel_first) begin
                    s_nxt.dword[15:8] = pin_now.data;
                end else begin
                    s_nxt.dword[7:0] = pin_now.data;
                end
            end
            // ACT_IDLE leaves everything untouched
        end
        case (s_r.state)
            ppp_pkg::PPP_IDLE: begin
                s_nxt.rdy = 1'b1;
                if (wr_fall && s_r.rdy) begin
                    if (start_flash || start_ee) begin
                        s_nxt.state = ppp_pkg::PPP_BUSY;
                        s_nxt.cnt = 32'(PROG_CYCLES);
                        s_nxt.rdy = 1'b0;
                    end else if (s_r.cmd == ppp_pkg::CMD_WR_FUSE) begin
                        s_nxt.state = ppp_pkg::PPP_BUSY;
                        s_nxt.cnt = 32'(PROG_CYCLES);
                        s_nxt.rdy = 1'b0;
                        // both selects high names no fuse byte, yet busy is still shown
                        if (!pin_now.byte_sel_first && !pin_now.byte_sel_second) begin
                            s_nxt.fuse_lo = s_r.dword[7:0];
                        end else if (pin_now.byte_sel_first && !pin_now.byte_sel_second) begin
                            s_nxt.fuse_hi = s_r.dword[7:0];
                        end else if (!pin_now.byte_sel_first && pin_now.byte_sel_second) begin
                            s_nxt.fuse_ext = s_r.dword[7:0];
                        end
                    end else if (s_r.cmd == ppp_pkg::CMD_WR_LOCK) begin
                        s_nxt.state = ppp_pkg::PPP_BUSY;
                        s_nxt.cnt = 32'(PROG_CYCLES);
                        s_nxt.rdy = 1'b0;
                        // only programming (1 to 0) is possible; never clears
                        if (!s_r.lock[ppp_pkg::LOCK_BIT_ONE_POS]
                            && !s_r.lock[ppp_pkg::LOCK_BIT_TWO_POS]) begin
                            // mode 3: boot lock bits keep their old value
                            s_nxt.lock = s_r.lock
                                & (s_r.dword[7:0] | ppp_pkg::LOCK_BOOT_MASK);
                        end else begin
                            s_nxt.lock = s_r.lock & s_r.dword[7:0];
                        end
                    end
                end
            end
            ppp_pkg::PPP_BUSY: begin
                s_nxt.rdy = 1'b0;
                s_nxt.cnt = s_r.cnt - 32'h0000_0001;
                if (done) begin
                    s_nxt.state = ppp_pkg::PPP_IDLE;
                    s_nxt.rdy = 1'b1;
                end
            end
            default: begin
                s_nxt.state = ppp_pkg::PPP_IDLE;
            end
        endcase
        // read path: output follows the enable, data reflects current selects
        // the bus is released one edge after out_en_n rises; the programmer must wait
        s_nxt.oe = !pin_now.out_en_n;
        s_nxt.dout = 8'hFF;
        case (s_r.cmd)
            ppp_pkg::CMD_RD_FLASH: begin
                s_nxt.dout = pin_now.byte_sel_first ? flash_mem[faddr][15:8]
                                                    : flash_mem[faddr][7:0];
            end
            ppp_pkg::CMD_RD_EE: begin
                s_nxt.dout = ee_mem[eaddr];
            end
            ppp_pkg::CMD_RD_FUSE: begin
                case ({pin_now.byte_sel_second, pin_now.byte_sel_first})
                    2'h0: s_nxt.dout = s_r.fuse_lo;
                    2'h3: s_nxt.dout = s_r.fuse_hi;
                    2'h2: s_nxt.dout = s_r.fuse_ext;
                    default: s_nxt.dout = s_r.lock;
                endcase
            end
            ppp_pkg::CMD_RD_SIG: begin
                // addresses past the last identity byte read as all ones
                if (pin_now.byte_sel_first) begin
                    s_nxt.dout = (s_r.addr[7:0] == 8'h00) ? CALIB : 8'hFF;
                end else if (s_r.addr[7:0] == 8'h00) begin
                    s_nxt.dout = SIG0;
                end else if (s_r.addr[7:0] == 8'h01) begin
                    s_nxt.dout = SIG1;
                end else if (s_r.addr[7:0] == 8'(ppp_pkg::SIG_LAST)) begin
                    s_nxt.dout = SIG2;
                end
            end
            default: begin
                s_nxt.dout = 8'hFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '{pins: '{load: 1'b0, latch: 1'b0, write_n: 1'b1, out_en_n: 1'b1,
                             action: ppp_pkg::ACT_IDLE, byte_sel_first: 1'b0,
                             byte_sel_second: 1'b0, data: 8'h00},
                     state: ppp_pkg::PPP_IDLE, cmd: ppp_pkg::CMD_NOP, addr: 16'h0000,
                     dword: 16'hFFFF, fuse_lo: ppp_pkg::FUSE_LO_RST,
                     fuse_hi: ppp_pkg::FUSE_HI_RST, fuse_ext: ppp_pkg::FUSE_EXT_RST,
                     lock: ppp_pkg::LOCK_RST, cnt: 32'h0000_0000, dout: 8'h00,
                     oe: 1'b0, rdy: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // page buffer valid flags; a new nop command or a finished write clears them
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fbuf_vld_r <= '0;
            ebuf_vld_r <= '0;
        end else begin
            if ((load_rise && pin_now.action == ppp_pkg::ACT_CMD && !pin_now.byte_sel_first
                 && pin_now.data == ppp_pkg::CMD_NOP) || done) begin
                fbuf_vld_r <= '0;
                ebuf_vld_r <= '0;
            end
            // a latch in the same cycle as a clear still marks its slot
            if (latch_rise && pin_now.byte_sel_first
                && s_r.cmd == ppp_pkg::CMD_WR_FLASH) begin
                fbuf_vld_r[faddr[FW-1:0]] <= 1'b1;
            end
            if (latch_rise && s_r.cmd == ppp_pkg::CMD_WR_EE) begin
                ebuf_vld_r[eaddr[EW-1:0]] <= 1'b1;
            end
        end
    end

    // array writes: only locations latched into the buffer are altered
    always_ff @(posedge sys_clk_i) begin
        if (latch_rise && pin_now.byte_sel_first && s_r.cmd == ppp_pkg::CMD_WR_FLASH) begin
            fbuf[faddr[FW-1:0]] <= s_r.dword;
        end
        if (latch_rise && s_r.cmd == ppp_pkg::CMD_WR_EE) begin
            ebuf[eaddr[EW-1:0]] <= s_r.dword[7:0];
        end
        // the array takes the page at the start edge; busy models the self-timed write
        if (start_flash) begin
            for (int i = 0; i < FLASH_PAGE; i++) begin
                if (fbuf_vld_r[i]) begin
                    flash_mem[fpage_base | FA'(i)] <= fbuf[i];
                end
            end
        end
        if (start_ee) begin
            for (int i = 0; i < EE_PAGE; i++) begin
                if (ebuf_vld_r[i]) begin
                    ee_mem[epage_base | EA'(i)] <= ebuf[i];
                end
            end
        end
    end

    assign data_o = s_r.dout;
    assign data_oe_o = s_r.oe;
    assign ready_busy_o = s_r.rdy;
endmodule // ppp_port

// file: ppp_port_checker.sv
/*
 * ppp_port_checker: port-level timing checks for the programming port.
 * Assumes it is bound to ppp_port and that the programmer never reads while busy.
 */
`timescale 1ns/1ps
module ppp_port_checker #(
    parameter int PROG_CYCLES = ppp_pkg::PROG_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic load_strobe_i,
    input wire logic page_latch_i,
    input wire logic write_n_i,
    input wire logic out_en_n_i,
    input wire logic action_sel_hi_i,
    input wire logic action_sel_lo_i,
    input wire logic byte_sel_first_i,
    input wire logic byte_sel_second_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic ready_busy_o
);
    logic [15:0] busy_cnt_r;
    logic [15:0] busy_cnt_nxt;

    // counts sampled busy cycles so the run length can be checked against a parameter
    always_comb begin
        busy_cnt_nxt = ready_busy_o ? 16'h0000 : busy_cnt_r + 16'h0001;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt_r <= 16'h0000;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // strobe quiet for three samples: a fresh command or address needs two edges to show
    sequence s_sel_steady;
        data_oe_o && $stable(byte_sel_first_i) && $stable(byte_sel_second_i) && ready_busy_o
            && !load_strobe_i && !$past(load_strobe_i) && !$past(load_strobe_i, 2);
    endsequence

    a_oe_tracks_enable: assert property (data_oe_o == !$past(out_en_n_i))
        else $error("data bus enable does not follow output enable");
    a_busy_on_write: assert property (
        $fell(write_n_i) && ready_busy_o |=> !ready_busy_o)
        else $error("write strobe did not start busy");
    a_busy_needs_write: assert property (
        $fell(ready_busy_o) |-> $past(write_n_i, 2) && !$past(write_n_i))
        else $error("busy began without a write strobe");
    a_ready_holds_idle: assert property (ready_busy_o && write_n_i |=> ready_busy_o)
        else $error("ready dropped with write strobe high");
    a_busy_length_exact: assert property (
        $rose(ready_busy_o) |-> busy_cnt_r == 16'(PROG_CYCLES))
        else $error("busy period has the wrong length");
    a_busy_no_overrun: assert property (!ready_busy_o |-> busy_cnt_r < 16'(PROG_CYCLES))
        else $error("busy period overran");
    a_busy_ends_bounded: assert property (
        $fell(ready_busy_o) |-> ##[1:1000] ready_busy_o)
        else $error("busy never ended");
    a_read_data_steady: assert property (
        s_sel_steady ##1 s_sel_steady |-> $stable(data_o))
        else $error("read data changed with selects steady");
endmodule // ppp_port_checker

bind ppp_port ppp_port_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .load_strobe_i(load_strobe_i),
    .page_latch_i(page_latch_i), .write_n_i(write_n_i), .out_en_n_i(out_en_n_i),
    .action_sel_hi_i(action_sel_hi_i), .action_sel_lo_i(action_sel_lo_i),
    .byte_sel_first_i(byte_sel_first_i), .byte_sel_second_i(byte_sel_second_i),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .ready_busy_o(ready_busy_o));

// file: ppp_prog_model.sv
/*
 * ppp_prog_model: external programmer driving the port pins through tasks.
 * Assumes the caller runs on sys_clk_i; pins change only by NBA at rising edges.
 */
`timescale 1ns/1ps
module ppp_prog_model (
    input wire logic sys_clk_i,
    input wire logic ready_busy_i,
    input wire logic dev_oe_i,
    input wire logic [7:0] dev_data_i,
    output ppp_pkg::ppp_pins_t pins_o,
    output logic [7:0] bus_o
);
    initial begin
        pins_o = '{load: 1'b0, latch: 1'b0, write_n: 1'b1, out_en_n: 1'b1, action: 2'h3,
                   byte_sel_first: 1'b0, byte_sel_second: 1'b0, data: 8'h00};
    end

    // bus enabled but not yet driven by the device shows the inverted last value so a stale level cannot pass for data
    assign bus_o = dev_oe_i ? dev_data_i : (pins_o.out_en_n ? pins_o.data : ~pins_o.data);

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    task automatic ld(input logic [1:0] act, input logic sel1, input logic [7:0] d);
        tick(1);
        pins_o.action <= act;
        pins_o.byte_sel_first <= sel1;
        pins_o.data <= d;
        tick(2);
        pins_o.load <= 1'b1;
        tick(2);
        pins_o.load <= 1'b0;
        tick(1);
    endtask

    task automatic latch();
        tick(1);
        pins_o.byte_sel_first <= 1'b1;
        tick(2);
        pins_o.latch <= 1'b1;
        tick(2);
        pins_o.latch <= 1'b0;
        tick(1);
    endtask

    // ok only when busy was seen and ready came back within the bound
    task automatic wr(input logic sel1, input logic sel2, output logic ok);
        tick(1);
        pins_o.byte_sel_first <= sel1;
        pins_o.byte_sel_second <= sel2;
        tick(2);
        pins_o.write_n <= 1'b0;
        tick(2);
        ok = (ready_busy_i === 1'b0);
        pins_o.write_n <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            tick(1);
            if (ready_busy_i === 1'b1) begin
                return;
            end
        end
        ok = 1'b0;
    endtask

    task automatic rd(input logic sel1, input logic sel2, output logic [7:0] d);
        tick(1);
        pins_o.byte_sel_first <= sel1;
        pins_o.byte_sel_second <= sel2;
        pins_o.out_en_n <= 1'b0;
        tick(3);
        d = bus_o;
        pins_o.out_en_n <= 1'b1;
        tick(2);
    endtask
endmodule // ppp_prog_model

// file: tb_parallel_nvm_programming_port.sv
/*
 * tb_parallel_nvm_programming_port: sequences of programmer calls with expected values.
 * Assumes ppp_port with a 4-cycle programming time and 64-word flash pages.
 */
`timescale 1ns/1ps
module tb_parallel_nvm_programming_port;
    localparam logic [7:0] SIG0 = 8'h5A; // arbitrary identity value
    localparam logic [7:0] SIG1 = 8'h6B; // arbitrary identity value
    localparam logic [7:0] SIG2 = 8'h7C; // arbitrary identity value
    localparam logic [7:0] CALIB = 8'h9D;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ppp_pkg::ppp_pins_t pins;
    logic [7:0] bus;
    logic [7:0] dout;
    logic data_oe;
    logic ready_busy;
    logic [7:0] rd_v;
    logic ok;
    int fail_count = 0;
    int check_count = 0;
    logic [7:0] sig_v [3] = '{SIG0, SIG1, SIG2};
    logic [7:0] fuse_v [3] = '{8'hE2, 8'hD9, 8'hF8};
    logic fw_s1 [3] = '{1'b0, 1'b1, 1'b0};
    logic fw_s2 [3] = '{1'b0, 1'b0, 1'b1};
    logic fr_s1 [3] = '{1'b0, 1'b1, 1'b0};
    logic fr_s2 [3] = '{1'b0, 1'b1, 1'b1};

    always #2.5 clk = ~clk;

    ppp_port #(.PROG_CYCLES(4), .SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CALIB(CALIB)) uut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .load_strobe_i(pins.load), .page_latch_i(pins.latch),
        .write_n_i(pins.write_n), .out_en_n_i(pins.out_en_n), .action_sel_hi_i(pins.action[1]),
        .action_sel_lo_i(pins.action[0]), .byte_sel_first_i(pins.byte_sel_first),
        .byte_sel_second_i(pins.byte_sel_second), .data_i(bus), .data_o(dout),
        .data_oe_o(data_oe), .ready_busy_o(ready_busy));

    ppp_prog_model prog (.sys_clk_i(clk), .ready_busy_i(ready_busy), .dev_oe_i(data_oe),
        .dev_data_i(dout), .pins_o(pins), .bus_o(bus));

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic s1, input logic s2, input logic [7:0] exp);
        prog.rd(s1, s2, rd_v);
        check(rd_v, exp);
    endtask

    // a timed-out wait ends the run at once
    task automatic wr_chk(input logic s1, input logic s2);
        prog.wr(s1, s2, ok);
        check({7'h00, ok}, 8'h01);
        if (ok !== 1'b1) begin
            stop_test();
        end
    endtask

    task automatic cmd(input logic [7:0] c);
        prog.ld(ppp_pkg::ACT_CMD, 1'b0, c);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({7'h00, ready_busy}, 8'h01);
        check({7'h00, data_oe}, 8'h00);
        // two words in page 5: top bits of the low address byte and the high byte pick the page
        cmd(ppp_pkg::CMD_WR_FLASH);
        for (int i = 0; i < 2; i++) begin
            prog.ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h45 + 8'(i));
            prog.ld(ppp_pkg::ACT_DATA, 1'b0, 8'hC0 + 8'(i));
            prog.ld(ppp_pkg::ACT_DATA, 1'b1, 8'h30 + 8'(i));
            prog.latch();
        end
        prog.ld(ppp_pkg::ACT_ADDR, 1'b1, 8'h01);
        wr_chk(1'b0, 1'b0);
        cmd(ppp_pkg::CMD_NOP);
        // a word latched before a nop must not reach the array at the next write
        cmd(ppp_pkg::CMD_WR_FLASH);
        prog.ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h45);
        prog.ld(ppp_pkg::ACT_DATA, 1'b0, 8'hEE);
        prog.latch();
        cmd(ppp_pkg::CMD_NOP);
        cmd(ppp_pkg::CMD_WR_FLASH);
        wr_chk(1'b0, 1'b0);
        cmd(ppp_pkg::CMD_RD_FLASH);
        for (int i = 0; i < 2; i++) begin
            prog.ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h45 + 8'(i));
            rd_chk(1'b0, 1'b0, 8'hC0 + 8'(i));
            rd_chk(1'b1, 1'b0, 8'h30 + 8'(i));
        end
        prog.ld(ppp_pkg::ACT_IDLE, 1'b0, 8'h45);
        rd_chk(1'b0, 1'b0, 8'hC1);
        cmd(ppp_pkg::CMD_WR_EE);
        prog.ld(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
        for (int i = 0; i < 2; i++) begin
            prog.ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h09 + 8'(i));
            prog.ld(ppp_pkg::ACT_DATA, 1'b0, 8'hA5 ^ 8'(i * 255));
            prog.latch();
        end
        wr_chk(1'b0, 1'b0);
        cmd(ppp_pkg::CMD_RD_EE);
        for (int i = 0; i < 2; i++) begin
            prog.ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h09 + 8'(i));
            rd_chk(1'b0, 1'b0, 8'hA5 ^ 8'(i * 255));
        end
        cmd(ppp_pkg::CMD_WR_FUSE);
        for (int i = 0; i < 3; i++) begin
            prog.ld(ppp_pkg::ACT_DATA, 1'b0, fuse_v[i]);
            wr_chk(fw_s1[i], fw_s2[i]);
        end
        cmd(ppp_pkg::CMD_RD_FUSE);
        for (int i = 0; i < 3; i++) begin
            rd_chk(fr_s1[i], fr_s2[i], fuse_v[i]);
        end
        rd_chk(1'b1, 1'b0, ppp_pkg::LOCK_RST);
        // mode 3 first, then a boot-bit attempt and an erase attempt
        cmd(ppp_pkg::CMD_WR_LOCK);
        prog.ld(ppp_pkg::ACT_DATA, 1'b0, 8'hFC);
        wr_chk(1'b0, 1'b0);
        prog.ld(ppp_pkg::ACT_DATA, 1'b0, 8'hC3);
        wr_chk(1'b0, 1'b0);
        prog.ld(ppp_pkg::ACT_DATA, 1'b0, 8'hFF);
        wr_chk(1'b0, 1'b0);
        cmd(ppp_pkg::CMD_RD_FUSE);
        rd_chk(1'b1, 1'b0, 8'hFC);
        cmd(ppp_pkg::CMD_RD_SIG);
        for (int i = 0; i < 3; i++) begin
            prog.ld(ppp_pkg::ACT_ADDR, 1'b0, 8'(i));
            rd_chk(1'b0, 1'b0, sig_v[i]);
        end
        prog.ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h00);
        rd_chk(1'b1, 1'b0, CALIB);
        stop_test();
    end
endmodule // tb_parallel_nvm_programming_port
